// ==== hdl/sfwc_pkg.sv ====
// Shared constants, register map and carrier types of the FIFO watermark block.
`default_nettype none

package sfwc_pkg;

	localparam int DATA_W   = 16;
	localparam int DEPTH    = 16;
	localparam int CNT_W    = 5;
	localparam int WM_W     = 4;
	localparam int APB_DW   = 32;
	localparam int IRQ_N    = 4;

	localparam logic [7:0] OFF_FIFO_CONTROL    = 8'h00;
	localparam logic [7:0] OFF_FIFO_FILL_COUNT = 8'h04;
	localparam logic [7:0] OFF_INT_STATUS      = 8'h08;
	localparam logic [7:0] OFF_INT_MASK        = 8'h0C;
	localparam logic [7:0] OFF_TX_FIFO_DATA    = 8'h10;
	localparam logic [7:0] OFF_RX_FIFO_DATA    = 8'h14;

	localparam int POS_RX_COUNT = 8;
	localparam int POS_TX_COUNT = 0;

	localparam logic [15:0] RST_FIFO_CONTROL = 16'h0000;
	localparam logic [3:0]  RST_INT_MASK     = 4'h0;
	localparam logic [3:0]  CTRL_WR_HI_MASK  = 4'hF;

	localparam int IRQ_RX_FULL     = 0;
	localparam int IRQ_TX_EMPTY    = 1;
	localparam int IRQ_RX_OVERRUN  = 2;
	localparam int IRQ_TX_UNDERRUN = 3;

	typedef struct packed {
		logic [3:0] reserved;
		logic       trmd;
		logic       lm;
		logic       rx_fifo_reset;
		logic       tx_fifo_reset;
		logic [3:0] rx_watermark;
		logic [3:0] tx_watermark;
	} sfwc_ctrl_t;

	typedef struct packed {
		logic [2:0] rsvd_hi;
		logic [4:0] rx_count;
		logic [2:0] rsvd_lo;
		logic [4:0] tx_count;
	} sfwc_count_t;

	typedef enum logic [0:0] {
		APB_IDLE = 1'b0,
		APB_DONE = 1'b1
	} sfwc_apb_state_t;

endpackage : sfwc_pkg

`default_nettype wire

// ==== hdl/sfwc_fifo.sv ====
// Flip-flop FIFO with fill count and flush, used for both directions.
`default_nettype none

module sfwc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16,
	parameter int CW    = 5
) (
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic             ce,
	input  wire logic             flush,
	input  wire logic             push,
	input  wire logic [WIDTH-1:0] push_data,
	input  wire logic             pop,
	output logic      [WIDTH-1:0] pop_data,
	output logic      [CW-1:0]    count,
	output logic                  full,
	output logic                  empty
);

	localparam int PW = $clog2(DEPTH);
	localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic             push_ok;
	logic             pop_ok;

	assign full     = (count == CNT_FULL);
	assign empty    = (count == '0);
	assign push_ok  = push && !full && !flush;
	assign pop_ok   = pop && !empty && !flush;
	assign pop_data = mem[rd_ptr];

	always_ff @(posedge mclk)
	begin
		if (ce && push_ok)
			mem[wr_ptr] <= push_data;
	end

	always_ff @(posedge mclk)
	begin
		if (rst || (ce && flush))
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else if (ce)
		begin
			if (push_ok)
				wr_ptr <= PW'(wr_ptr + 1'b1);
			if (pop_ok)
				rd_ptr <= PW'(rd_ptr + 1'b1);
			if (push_ok && !pop_ok)
				count <= CW'(count + 1'b1);
			else if (pop_ok && !push_ok)
				count <= CW'(count - 1'b1);
		end
	end

endmodule : sfwc_fifo

`default_nettype wire

// ==== hdl/sfwc_irq.sv ====
// Sticky interrupt status with write-one-to-clear, mask and one level output.
`default_nettype none

module sfwc_irq #(
	parameter int N = 4
) (
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic         ce,
	input  wire logic [N-1:0] set_ev,
	input  wire logic         clr_we,
	input  wire logic [N-1:0] clr_bits,
	input  wire logic         mask_we,
	input  wire logic [N-1:0] mask_bits,
	output logic      [N-1:0] status,
	output logic      [N-1:0] mask,
	output logic              irq
);

	assign irq = |(status & mask);

	always_ff @(posedge mclk)
	begin
		if (rst)
			status <= '0;
		else if (ce)
			status <= (status & ~(clr_we ? clr_bits : '0)) | set_ev;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			mask <= N'(sfwc_pkg::RST_INT_MASK);
		else if (ce && mask_we)
			mask <= mask_bits;
	end

endmodule : sfwc_irq

`default_nettype wire

// ==== hdl/sfwc_top.sv ====
// FIFO reset, watermark flags and fill count of a synchronous serial port.
// Notes on behaviour
// [RQ1] Transmit reset flushes FIFO, clears its flags; here only the underrun flag clears, the empty flag is held high.
// [RQ2] FIFO reset holds while its bit stays one.
// [RQ3] Receive full when count reaches threshold.
// [RQ4] Receive threshold is field plus one.
// [RQ5] Transmit empty when count at most threshold.
// [RQ6] Transmit threshold equals field value.
// [RQ7] Count register: receive high, transmit low.
// [RQ8] Count clears on reset or FIFO reset.
// [RQ9] Receive count spans zero to sixteen.
// [RQ10] Receive count drops on each FIFO read.
// [RQ11] Transmit count shows entries still unsent.
// [RQ12] Transmit count drops per entry shifted.
// [RQ13] Disable port before changing mode fields.
// [RQ14] Receive reset flushes FIFO, clears its flags.
// [RQ15] Watermark flags follow counts every cycle.
//
// Chosen here: the placing of the registers and the APB register port.
`default_nettype none

module sfwc_top #(
	parameter int ADDR_W = 8,
	parameter int DATA_W = sfwc_pkg::DATA_W,
	parameter int DEPTH  = sfwc_pkg::DEPTH
) (
	input  wire logic                          mclk,
	input  wire logic                          rst,
	input  wire logic                          ce,
	input  wire logic [ADDR_W-1:0]             paddr,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [sfwc_pkg::APB_DW-1:0]   pwdata,
	input  wire logic [3:0]                    pstrb,
	output logic      [sfwc_pkg::APB_DW-1:0]   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic                          rx_push,
	input  wire logic [DATA_W-1:0]             rx_push_data,
	input  wire logic                          tx_pop,
	output logic      [DATA_W-1:0]             tx_pop_data,
	output logic                               tx_pop_valid,
	input  wire logic                          rx_overrun_clr,
	input  wire logic                          tx_underrun_clr,
	output logic                               rx_full_flag,
	output logic                               tx_empty_flag,
	output logic                               rx_overrun_flag,
	output logic                               tx_underrun_flag,
	output logic                               trmd,
	output logic                               lm,
	output logic                               irq
);

	localparam int CW = sfwc_pkg::CNT_W;
	localparam int WW = sfwc_pkg::WM_W;
	localparam int QN = sfwc_pkg::IRQ_N;

	sfwc_pkg::sfwc_ctrl_t      fifo_control;
	sfwc_pkg::sfwc_count_t     fifo_fill_count;
	sfwc_pkg::sfwc_apb_state_t apb_state;
	sfwc_pkg::sfwc_apb_state_t next_apb_state;

	logic [CW-1:0]     rx_count;
	logic [CW-1:0]     tx_count;
	logic              rx_full;
	logic              rx_empty;
	logic              tx_full;
	logic              tx_empty;
	logic [DATA_W-1:0] rx_head;
	logic              rx_pop;
	logic              tx_push;
	logic [CW-1:0]     rx_threshold;
	logic [CW-1:0]     tx_threshold;
	logic              rx_full_prev;
	logic              tx_empty_prev;
	logic [QN-1:0]     irq_set;
	logic [QN-1:0]     int_status;
	logic [QN-1:0]     int_mask;
	logic              apb_access;
	logic              apb_commit;
	logic              wr_commit;
	logic              rd_commit;
	logic              addr_mapped;
	logic [sfwc_pkg::APB_DW-1:0] read_value;

	// One decoder serves the write strobes, the read mux and the error answer.
	function automatic logic reg_hit(
		input logic [ADDR_W-1:0] addr,
		input logic [7:0]        offset
	);
		reg_hit = (addr == ADDR_W'(offset));
	endfunction : reg_hit

	// APB slave: one wait state, so read data and pready both come from flops.
	assign apb_access = psel && penable;
	assign apb_commit = apb_access && (apb_state == sfwc_pkg::APB_DONE);
	assign wr_commit  = apb_commit && pwrite && !pslverr;
	assign rd_commit  = apb_commit && !pwrite && !pslverr;
	assign pready     = (apb_state == sfwc_pkg::APB_DONE);

	assign addr_mapped = reg_hit(paddr, sfwc_pkg::OFF_FIFO_CONTROL)
		|| reg_hit(paddr, sfwc_pkg::OFF_FIFO_FILL_COUNT)
		|| reg_hit(paddr, sfwc_pkg::OFF_INT_STATUS)
		|| reg_hit(paddr, sfwc_pkg::OFF_INT_MASK)
		|| reg_hit(paddr, sfwc_pkg::OFF_TX_FIFO_DATA)
		|| reg_hit(paddr, sfwc_pkg::OFF_RX_FIFO_DATA);

	always_comb
	begin
		next_apb_state = apb_state;
		case (apb_state)
			sfwc_pkg::APB_IDLE:
				if (apb_access)
					next_apb_state = sfwc_pkg::APB_DONE;
			sfwc_pkg::APB_DONE:
				next_apb_state = sfwc_pkg::APB_IDLE;
			default:
				next_apb_state = sfwc_pkg::APB_IDLE;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			apb_state <= sfwc_pkg::APB_IDLE;
		else if (ce)
			apb_state <= next_apb_state;
	end

	always_comb
	begin
		read_value = '0;
		if (reg_hit(paddr, sfwc_pkg::OFF_FIFO_CONTROL))
			read_value = {16'h0000, fifo_control};
		else if (reg_hit(paddr, sfwc_pkg::OFF_FIFO_FILL_COUNT))
			read_value = {16'h0000, fifo_fill_count};
		else if (reg_hit(paddr, sfwc_pkg::OFF_INT_STATUS))
			read_value = {28'h0000000, int_status};
		else if (reg_hit(paddr, sfwc_pkg::OFF_INT_MASK))
			read_value = {28'h0000000, int_mask};
		else if (reg_hit(paddr, sfwc_pkg::OFF_RX_FIFO_DATA) && !rx_empty)
			read_value = {{(sfwc_pkg::APB_DW - DATA_W){1'b0}}, rx_head};
	end

	// Read data is caught in the first access cycle and held for the answer.
	// The error answer stands only in the cycle that carries pready.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end
		else if (ce && apb_access && apb_state == sfwc_pkg::APB_IDLE)
		begin
			prdata  <= pwrite ? '0 : read_value;
			pslverr <= !addr_mapped;
		end
		else if (ce && apb_state == sfwc_pkg::APB_DONE)
			pslverr <= 1'b0;
	end

	// Reserved bits 15..12 are never stored, so they always read as zero.
	always_ff @(posedge mclk)
	begin
		if (rst)
			fifo_control <= sfwc_pkg::RST_FIFO_CONTROL;
		else if (ce && wr_commit
			&& reg_hit(paddr, sfwc_pkg::OFF_FIFO_CONTROL))
		begin
			if (pstrb[0])
			begin
				fifo_control.rx_watermark <= pwdata[7:4];
				fifo_control.tx_watermark <= pwdata[3:0];
			end
			if (pstrb[1])
			begin
				fifo_control.trmd          <= pwdata[11];
				fifo_control.lm            <= pwdata[10];
				fifo_control.rx_fifo_reset <= pwdata[9]; // [RQ2]
				fifo_control.tx_fifo_reset <= pwdata[8]; // [RQ2]
			end
		end
	end

	assign trmd = fifo_control.trmd;
	assign lm   = fifo_control.lm;

	// Mode and watermark fields are taken as written; the port must be idle
	// while they change, or a flag may glitch for one cycle. [RQ13]

	assign rx_pop  = rd_commit && reg_hit(paddr, sfwc_pkg::OFF_RX_FIFO_DATA); // [RQ10]
	assign tx_push = wr_commit && reg_hit(paddr, sfwc_pkg::OFF_TX_FIFO_DATA)
		&& (pstrb[1:0] != 2'b00);

	// Flush is held for as long as the reset bit stays set. [RQ14] [RQ2]
	sfwc_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (DEPTH),
		.CW    (CW)
	) u_rx_fifo (
		.mclk      (mclk),
		.rst       (rst),
		.ce        (ce),
		.flush     (fifo_control.rx_fifo_reset),
		.push      (rx_push),
		.push_data (rx_push_data),
		.pop       (rx_pop),
		.pop_data  (rx_head),
		.count     (rx_count),
		.full      (rx_full),
		.empty     (rx_empty)
	);

	// Flush is held for as long as the reset bit stays set. [RQ1] [RQ2]
	sfwc_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (DEPTH),
		.CW    (CW)
	) u_tx_fifo (
		.mclk      (mclk),
		.rst       (rst),
		.ce        (ce),
		.flush     (fifo_control.tx_fifo_reset),
		.push      (tx_push),
		.push_data (pwdata[DATA_W-1:0]),
		.pop       (tx_pop),
		.pop_data  (tx_pop_data),
		.count     (tx_count),
		.full      (tx_full),
		.empty     (tx_empty)
	);

	assign tx_pop_valid = !tx_empty; // [RQ12]

	// Counts go straight out; each half is zero while its FIFO is flushed.
	always_comb
	begin
		fifo_fill_count          = '0; // [RQ7]
		fifo_fill_count.rx_count = rx_count; // [RQ9] [RQ8]
		fifo_fill_count.tx_count = tx_count; // [RQ11] [RQ8]
	end

	assign rx_threshold = CW'(fifo_control.rx_watermark) + CW'(1); // [RQ4]
	assign tx_threshold = CW'(fifo_control.tx_watermark); // [RQ6]

	// Compared combinationally so a push, pop or watermark change shows at once.
	assign rx_full_flag  = (rx_count >= rx_threshold); // [RQ3] [RQ15]
	assign tx_empty_flag = (tx_count <= tx_threshold); // [RQ5] [RQ15]

	// Error flags: set wins over the status clear, but a held FIFO reset
	// keeps them cleared.
	always_ff @(posedge mclk)
	begin
		if (rst || (ce && fifo_control.rx_fifo_reset))
			rx_overrun_flag <= 1'b0; // [RQ14]
		else if (ce && rx_push && rx_full)
			rx_overrun_flag <= 1'b1;
		else if (ce && rx_overrun_clr)
			rx_overrun_flag <= 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		if (rst || (ce && fifo_control.tx_fifo_reset))
			tx_underrun_flag <= 1'b0; // [RQ1]
		else if (ce && tx_pop && tx_empty)
			tx_underrun_flag <= 1'b1;
		else if (ce && tx_underrun_clr)
			tx_underrun_flag <= 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		// The empty flag idles high after reset, so its edge detector starts
		// high too; otherwise a false rise would be latched at once.
		if (rst)
		begin
			rx_full_prev  <= 1'b0;
			tx_empty_prev <= 1'b1;
		end
		else if (ce)
		begin
			rx_full_prev  <= rx_full_flag;
			tx_empty_prev <= tx_empty_flag;
		end
	end

	always_comb
	begin
		irq_set = '0;
		irq_set[sfwc_pkg::IRQ_RX_FULL]     = rx_full_flag && !rx_full_prev;
		irq_set[sfwc_pkg::IRQ_TX_EMPTY]    = tx_empty_flag && !tx_empty_prev;
		irq_set[sfwc_pkg::IRQ_RX_OVERRUN]  = rx_push && rx_full
			&& !fifo_control.rx_fifo_reset;
		irq_set[sfwc_pkg::IRQ_TX_UNDERRUN] = tx_pop && tx_empty
			&& !fifo_control.tx_fifo_reset;
	end

	sfwc_irq #(
		.N (QN)
	) u_irq (
		.mclk      (mclk),
		.rst       (rst),
		.ce        (ce),
		.set_ev    (irq_set),
		.clr_we    (wr_commit && pstrb[0]
			&& reg_hit(paddr, sfwc_pkg::OFF_INT_STATUS)),
		.clr_bits  (pwdata[QN-1:0]),
		.mask_we   (wr_commit && pstrb[0]
			&& reg_hit(paddr, sfwc_pkg::OFF_INT_MASK)),
		.mask_bits (pwdata[QN-1:0]),
		.status    (int_status),
		.mask      (int_mask),
		.irq       (irq)
	);

	// A full transmit FIFO simply drops a further write; software is
	// expected to watch the count or the empty flag first.
	logic unused_tx_full;
	assign unused_tx_full = tx_full;

endmodule : sfwc_top

`default_nettype wire

// ==== verif/sfwc_chk.sv ====
// Port checker for the FIFO watermark block.
`default_nettype none

module sfwc_chk (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        rx_push,
	input wire logic        tx_pop_valid,
	input wire logic        rx_full_flag,
	input wire logic        tx_empty_flag,
	input wire logic        rx_overrun_flag,
	input wire logic        tx_underrun_flag
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	logic [9:0] ctl;
	logic       wr_ctl;

	// Shadow of the control word, taken at the completing edge of a write.
	assign wr_ctl = psel && penable && pready && pwrite
		&& paddr == sfwc_pkg::OFF_FIFO_CONTROL;

	always_ff @(posedge mclk)
	begin
		if (rst)
			ctl <= 10'h000;
		else if (wr_ctl)
			ctl <= pwdata[9:0];
	end

	chk_ready_one_wait: assert property ((psel && !penable) ##1
		(psel && penable) |=> pready)
		else $error("pready missing in second access cycle");
	chk_ready_one_pulse: assert property (pready |=> !pready)
		else $error("pready held too long");
	chk_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_count_rsvd_zero: assert property (pready && !pwrite
		&& paddr == sfwc_pkg::OFF_FIFO_FILL_COUNT |-> prdata[31:13] == 19'h0
		&& prdata[7:5] == 3'h0)
		else $error("count reserved bits not zero");
	chk_tx_reset_flush: assert property (ctl[8] ##1 ctl[8] |->
		!tx_pop_valid && tx_empty_flag && !tx_underrun_flag)
		else $error("tx fifo not held empty in reset");
	chk_rx_reset_flush: assert property (ctl[9] ##1 ctl[9] |->
		!rx_full_flag && !rx_overrun_flag)
		else $error("rx fifo not held empty in reset");
	chk_rx_full_first: assert property (rx_push && !ctl[9]
		&& !wr_ctl && ctl[7:4] == 4'h0 |=> rx_full_flag)
		else $error("rx full missing at threshold one");
	chk_tx_empty_above: assert property (ctl[3:0] == 4'h0
		&& tx_pop_valid |-> !tx_empty_flag)
		else $error("tx empty set above threshold zero");
	chk_tx_empty_idle: assert property (
		!tx_pop_valid |-> tx_empty_flag)
		else $error("tx empty low with empty fifo");

	cover property (rx_full_flag && ctl[7:4] == 4'hF);
	cover property (pslverr);
	cover property (ctl[8] && ctl[9]);

endmodule : sfwc_chk

bind sfwc_top sfwc_chk i_chk (
	.mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.rx_push(rx_push), .tx_pop_valid(tx_pop_valid),
	.rx_full_flag(rx_full_flag), .tx_empty_flag(tx_empty_flag),
	.rx_overrun_flag(rx_overrun_flag),
	.tx_underrun_flag(tx_underrun_flag)
);

`default_nettype wire

// ==== verif/sfwc_top_tb.sv ====
// Self-checking bench for the FIFO watermark block.
`default_nettype none

module sfwc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  paddr = 8'h00;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rx_push = 1'b0;
	logic [15:0] rx_push_data = 16'h0;
	logic        tx_pop = 1'b0;
	logic [15:0] tx_pop_data;
	logic        tx_pop_valid;
	logic        rx_overrun_clr = 1'b0;
	logic        tx_underrun_clr = 1'b0;
	logic        rx_full_flag;
	logic        tx_empty_flag;
	logic        rx_overrun_flag;
	logic        tx_underrun_flag;
	logic        irq;
	logic        ce = 1'b1;
	logic        trmd;
	logic        lm;
	logic [31:0] rd;
	logic        er;
	int          num_errors = 0;
	int          total_checks = 0;
	int          cycles = 0;

	sfwc_top i_dut (
		.mclk(mclk), .rst(rst), .ce(ce), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.pstrb(4'hF), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_push(rx_push),
		.rx_push_data(rx_push_data), .tx_pop(tx_pop),
		.tx_pop_data(tx_pop_data), .tx_pop_valid(tx_pop_valid),
		.rx_overrun_clr(rx_overrun_clr),
		.tx_underrun_clr(tx_underrun_clr),
		.rx_full_flag(rx_full_flag), .tx_empty_flag(tx_empty_flag),
		.rx_overrun_flag(rx_overrun_flag),
		.tx_underrun_flag(tx_underrun_flag), .trmd(trmd), .lm(lm),
		.irq(irq)
	);

	always #5 mclk = ~mclk;

	task automatic report_and_stop();
		if (num_errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : report_and_stop

	// A hang in any wait ends here rather than running forever.
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			num_errors++;
			report_and_stop();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: %0h vs %0h", $time, seen, exp);
		end
	endtask : check

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do
			@(posedge mclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic push(input logic [15:0] d);
		@(posedge mclk);
		rx_push <= 1'b1;
		rx_push_data <= d;
		@(posedge mclk);
		rx_push <= 1'b0;
		rx_push_data <= ~d;
		@(posedge mclk);
	endtask : push

	task automatic pop();
		@(posedge mclk);
		tx_pop <= 1'b1;
		@(posedge mclk);
		tx_pop <= 1'b0;
		@(posedge mclk);
	endtask : pop

	task automatic t_reset();
		apb(1'b0, sfwc_pkg::OFF_FIFO_FILL_COUNT, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, sfwc_pkg::OFF_FIFO_CONTROL, 32'h0);
		check(rd, 32'h0);
		check(32'({rx_full_flag, tx_empty_flag}), 32'h1);
		apb(1'b0, sfwc_pkg::OFF_INT_STATUS, 32'h0);
		check(rd, 32'h0);
		apb(1'b1, sfwc_pkg::OFF_FIFO_CONTROL, 32'h0CA5);
		apb(1'b0, sfwc_pkg::OFF_FIFO_CONTROL, 32'h0);
		check(rd, 32'hCA5);
		check(32'({trmd, lm}), 32'h3);
		apb(1'b1, sfwc_pkg::OFF_FIFO_CONTROL, 32'h0);
	endtask : t_reset

	task automatic t_flush();
		pop();
		check(32'(tx_underrun_flag), 32'h1);
		push(16'h1111);
		apb(1'b1, sfwc_pkg::OFF_TX_FIFO_DATA, 32'h2222);
		apb(1'b1, sfwc_pkg::OFF_FIFO_CONTROL, 32'h300);
		apb(1'b0, sfwc_pkg::OFF_FIFO_FILL_COUNT, 32'h0);
		check(rd, 32'h0);
		push(16'h3333);
		apb(1'b1, sfwc_pkg::OFF_TX_FIFO_DATA, 32'h4444);
		apb(1'b0, sfwc_pkg::OFF_FIFO_FILL_COUNT, 32'h0);
		check(rd, 32'h0);
		check(32'({rx_full_flag, tx_empty_flag, tx_underrun_flag}),
			32'h2);
		apb(1'b1, sfwc_pkg::OFF_FIFO_CONTROL, 32'h0);
		push(16'hA5A5);
		apb(1'b0, sfwc_pkg::OFF_FIFO_FILL_COUNT, 32'h0);
		check(rd, 32'h100);
	endtask : t_flush

	task automatic t_irq();
		apb(1'b1, sfwc_pkg::OFF_INT_STATUS, 32'hF);
		pop();
		check(32'(irq), 32'h0);
		apb(1'b1, sfwc_pkg::OFF_INT_MASK, 32'h8);
		@(posedge mclk);
		check(32'(irq), 32'h1);
		apb(1'b0, sfwc_pkg::OFF_INT_STATUS, 32'h0);
		check(rd, 32'h8);
		apb(1'b1, sfwc_pkg::OFF_INT_STATUS, 32'h8);
		@(posedge mclk);
		check(32'(irq), 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		check(32'(er), 32'h1);
		apb(1'b1, sfwc_pkg::OFF_FIFO_FILL_COUNT, 32'hFFFF);
		apb(1'b0, sfwc_pkg::OFF_FIFO_FILL_COUNT, 32'h0);
		check(rd, 32'h100);
		apb(1'b0, sfwc_pkg::OFF_RX_FIFO_DATA, 32'h0);
		check(rd, 32'hA5A5);
	endtask : t_irq

	task automatic t_rx(input int wm);
		apb(1'b1, sfwc_pkg::OFF_FIFO_CONTROL, 32'(wm << 4));
		for (int i = 0; i < 16; i++)
		begin
			push(16'hA000 + 16'(i));
			check(32'(rx_full_flag), 32'(i >= wm));
		end
		apb(1'b0, sfwc_pkg::OFF_FIFO_FILL_COUNT, 32'h0);
		check(rd, 32'h1000);
		push(16'hBEEF);
		check(32'(rx_overrun_flag), 32'h1);
		for (int i = 0; i < 16; i++)
		begin
			apb(1'b0, sfwc_pkg::OFF_RX_FIFO_DATA, 32'h0);
			check(rd, 32'hA000 + 32'(i));
		end
		apb(1'b0, sfwc_pkg::OFF_FIFO_FILL_COUNT, 32'h0);
		check(rd, 32'h0);
		rx_overrun_clr <= 1'b1;
		@(posedge mclk);
		rx_overrun_clr <= 1'b0;
		@(posedge mclk);
		check(32'(rx_overrun_flag), 32'h0);
	endtask : t_rx

	task automatic t_tx(input int wm);
		apb(1'b1, sfwc_pkg::OFF_FIFO_CONTROL, 32'(wm));
		for (int i = 0; i < 16; i++)
		begin
			apb(1'b1, sfwc_pkg::OFF_TX_FIFO_DATA, 32'hC000 + 32'(i));
			@(posedge mclk);
			check(32'(tx_empty_flag), 32'(i + 1 <= wm));
		end
		apb(1'b0, sfwc_pkg::OFF_FIFO_FILL_COUNT, 32'h0);
		check(rd, 32'h10);
		ce <= 1'b0;
		pop();
		ce <= 1'b1;
		apb(1'b0, sfwc_pkg::OFF_FIFO_FILL_COUNT, 32'h0);
		check(rd, 32'h10);
		for (int i = 0; i < 16; i++)
		begin
			check(32'(tx_pop_data), 32'hC000 + 32'(i));
			pop();
			apb(1'b0, sfwc_pkg::OFF_FIFO_FILL_COUNT, 32'h0);
			check(rd, 32'(15 - i));
		end
		pop();
		check(32'(tx_underrun_flag), 32'h1);
		tx_underrun_clr <= 1'b1;
		@(posedge mclk);
		tx_underrun_clr <= 1'b0;
		@(posedge mclk);
		check(32'(tx_underrun_flag), 32'h0);
	endtask : t_tx

	initial
	begin
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		t_reset();
		t_flush();
		t_irq();
		t_rx(0);
		t_rx(7);
		t_rx(15);
		t_tx(0);
		t_tx(15);
		report_and_stop();
	end

endmodule : sfwc_top_tb

`default_nettype wire
